// ---- hw/tcc_cfg.svh ----
// constants for the timer compare and capture units
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// special-function register addresses
`define TCC_ADDR_U1_LO    8'hC2
`define TCC_ADDR_U1_HI    8'hC3
`define TCC_ADDR_U2_LO    8'hC4
`define TCC_ADDR_U2_HI    8'hC5
`define TCC_ADDR_U3_LO    8'hC6
`define TCC_ADDR_U3_HI    8'hC7
`define TCC_ADDR_CTRL     8'hC8
`define TCC_ADDR_MODE     8'hC9
`define TCC_ADDR_U0_LO    8'hCA
`define TCC_ADDR_U0_HI    8'hCB
`define TCC_ADDR_TMR_LO   8'hCC
`define TCC_ADDR_TMR_HI   8'hCD

// timer control fields
`define TCC_CTRL_RUN_BIT    0
`define TCC_CTRL_RELOAD_BIT 4
`define TCC_CTRL_SIZE_BIT   5

// field layout and reset values
`define TCC_MODE_FIELD_W  2
`define TCC_BYTE_RESET    8'h00
`define TCC_WORD_RESET    16'h0000
`define TCC_BYTE_ONE      8'h01
`define TCC_WORD_ONE      16'h0001

// pin capture latency in cycles after the synchronised edge
`define TCC_FALL_CAP_DLY  1
`define TCC_RISE_CAP_DLY  2

`endif

// ---- hw/tcc_pkg.sv ----
// types shared by the compare and capture units
package tcc_pkg;

   // per-unit operating mode held in a two-bit field
   typedef enum logic [1:0] {
      TCC_MODE_OFF  = 2'h0,
      TCC_MODE_PIN  = 2'h1,
      TCC_MODE_CMP  = 2'h2,
      TCC_MODE_SOFT = 2'h3
   } tcc_mode_t;

endpackage : tcc_pkg

// ---- hw/tcc_pin_sync.sv ----
// two-flop synchroniser for one capture pin
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_sync #(
   parameter bit RST_LEVEL = 1'b0
) (
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic pin_i,
   output logic      pin_sync_o
);

   logic meta_reg;

   // first stage is read only by the second stage
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         meta_reg   <= RST_LEVEL;
         pin_sync_o <= RST_LEVEL;
      end else begin
         meta_reg   <= pin_i;
         pin_sync_o <= meta_reg;
      end
   end

endmodule : tcc_pin_sync

`default_nettype wire

// ---- hw/tcc_unit.sv ----
// one compare and capture unit: value register, capture and compare
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_unit #(
   parameter bit HAS_PIN  = 1'b1,
   parameter bit PIN_FALL = 1'b0,
   parameter int PIN_DLY  = `TCC_RISE_CAP_DLY
) (
   input  wire logic              sys_clk_i,
   input  wire logic              srst_i,
   input  wire tcc_pkg::tcc_mode_t mode_i,
   input  wire logic              size8_i,
   input  wire logic [15:0]       timer_i,
   input  wire logic              pin_sync_i,
   input  wire logic              wr_lo_i,
   input  wire logic              wr_hi_i,
   input  wire logic [7:0]        wdata_i,
   output logic [15:0]            value_o,
   output logic                   pulse_o,
   output logic                   cap_o
);

   logic        pin_prev_reg;
   logic        edge_d_reg;
   logic [7:0]  lo_next;
   logic [7:0]  hi_next;
   logic        pulse_next;
   wire         pin_mode  = (mode_i == tcc_pkg::TCC_MODE_PIN) && HAS_PIN;
   wire         pin_edge  = pin_mode && (PIN_FALL ? (pin_prev_reg && !pin_sync_i)
                                                  : (!pin_prev_reg && pin_sync_i));
   wire         pin_cap   = (PIN_DLY == `TCC_FALL_CAP_DLY) ? pin_edge : (edge_d_reg && pin_mode);
   wire         soft_cap  = (mode_i == tcc_pkg::TCC_MODE_SOFT) && wr_lo_i;
   wire         cmp_hit   = size8_i ? (timer_i[7:0] >= value_o[7:0]) : (timer_i >= value_o);

   // capture wins over a software write in the same cycle
   assign cap_o      = pin_cap || soft_cap;
   assign lo_next    = cap_o ? timer_i[7:0] : (wr_lo_i ? wdata_i : value_o[7:0]);
   assign hi_next    = (cap_o && !size8_i) ? timer_i[15:8]
                     : (wr_hi_i ? wdata_i : value_o[15:8]);
   assign pulse_next = (mode_i == tcc_pkg::TCC_MODE_CMP) && cmp_hit;

   // non-idle pin level at reset so no false edge appears after release
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         pin_prev_reg <= !PIN_FALL;
         edge_d_reg   <= 1'b0;
         value_o      <= `TCC_WORD_RESET;
         pulse_o      <= 1'b0;
      end else begin
         pin_prev_reg <= pin_sync_i;
         edge_d_reg   <= pin_edge;           // extra stage for rising-edge units
         value_o      <= {hi_next, lo_next};
         pulse_o      <= pulse_next;
      end
   end

endmodule : tcc_unit

`default_nettype wire

// ---- hw/tcc_top.sv ----
// timer with four compare and capture units behind byte registers
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tcc_top (
   input  wire logic       sys_clk_i,
   input  wire logic       srst_i,
   input  wire logic [7:0] sfr_addr_i,
   input  wire logic       sfr_wr_i,
   input  wire logic       sfr_rd_i,
   input  wire logic [7:0] sfr_wdata_i,
   output logic [7:0]      sfr_rdata_o,
   input  wire logic       unit0_capture_pin_i,
   input  wire logic       unit1_capture_pin_i,
   input  wire logic       unit2_capture_pin_i,
   output logic [3:0]      unit_pulse_o,
   output logic            timer_overflow_o
);

   localparam int NUM_UNITS = 4;

   // software-visible state
   logic [7:0]          timer_control_reg;
   logic [7:0]          unit_mode_enable_reg;
   logic [15:0]         tmr_reg;
   logic [15:0]         tmr_next;
   logic [15:0]         tmr_count;
   logic [7:0]          rdata_next;

   // per-unit wiring
   logic [15:0]         unit_value [NUM_UNITS];
   tcc_pkg::tcc_mode_t  unit_mode  [NUM_UNITS];
   logic [NUM_UNITS-1:0] wr_lo;
   logic [NUM_UNITS-1:0] wr_hi;
   logic [NUM_UNITS-1:0] cap_fire;
   logic [NUM_UNITS-1:0] pin_raw;
   logic [NUM_UNITS-1:0] pin_sync;
   logic [NUM_UNITS-1:0] pulse_w;

   // control decode
   wire         run       = timer_control_reg[`TCC_CTRL_RUN_BIT];
   wire         size8     = timer_control_reg[`TCC_CTRL_SIZE_BIT];
   wire         reload_en = timer_control_reg[`TCC_CTRL_RELOAD_BIT];
   wire         ctrl_wr   = sfr_wr_i && (sfr_addr_i == `TCC_ADDR_CTRL);
   wire         mode_wr   = sfr_wr_i && (sfr_addr_i == `TCC_ADDR_MODE);
   wire         tmr_lo_wr = sfr_wr_i && (sfr_addr_i == `TCC_ADDR_TMR_LO);
   wire         tmr_hi_wr = sfr_wr_i && (sfr_addr_i == `TCC_ADDR_TMR_HI);

   // overflow at the top of the selected count width
   wire         ovf       = run && (size8 ? (&tmr_reg[7:0]) : (&tmr_reg));
   // reload needs the sixteen-bit count; a software write to the timer wins
   wire         reload_evt = ovf && reload_en && !size8 && !tmr_lo_wr && !tmr_hi_wr;
   wire [15:0]  tmr_inc16 = tmr_reg + `TCC_WORD_ONE;
   wire [15:0]  tmr_inc8  = {tmr_reg[15:8], tmr_reg[7:0] + `TCC_BYTE_ONE};

   // timer next value; captures only read the timer, never steer it
   assign tmr_count = reload_evt ? unit_value[0]
                    : (size8 ? tmr_inc8 : tmr_inc16);
   assign tmr_next[7:0]  = tmr_lo_wr ? sfr_wdata_i : (run ? tmr_count[7:0] : tmr_reg[7:0]);
   assign tmr_next[15:8] = tmr_hi_wr ? sfr_wdata_i : (run ? tmr_count[15:8] : tmr_reg[15:8]);

   // pins: unit 3 has no pin, its input is held at the idle level
   assign pin_raw = {1'b0, unit2_capture_pin_i, unit1_capture_pin_i, unit0_capture_pin_i};

   // one unit per generate pass, each with its own field and addresses
   generate
      for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
         localparam bit         IS_U0   = (g == 0);
         localparam logic [7:0] ADDR_LO = (g == 0) ? `TCC_ADDR_U0_LO :
                                          (g == 1) ? `TCC_ADDR_U1_LO :
                                          (g == 2) ? `TCC_ADDR_U2_LO : `TCC_ADDR_U3_LO;
         localparam logic [7:0] ADDR_HI = (g == 0) ? `TCC_ADDR_U0_HI :
                                          (g == 1) ? `TCC_ADDR_U1_HI :
                                          (g == 2) ? `TCC_ADDR_U2_HI : `TCC_ADDR_U3_HI;

         // field g sits at bits 2g+1:2g, upper bit is the high selector
         assign unit_mode[g] = tcc_pkg::tcc_mode_t'(
            unit_mode_enable_reg[`TCC_MODE_FIELD_W*g +: `TCC_MODE_FIELD_W]);
         assign wr_lo[g] = sfr_wr_i && (sfr_addr_i == ADDR_LO);
         assign wr_hi[g] = sfr_wr_i && (sfr_addr_i == ADDR_HI);

         tcc_pin_sync #(
            .RST_LEVEL (IS_U0)
         ) u_sync (
            .sys_clk_i  (sys_clk_i),
            .srst_i     (srst_i),
            .pin_i      (pin_raw[g]),
            .pin_sync_o (pin_sync[g])
         );

         tcc_unit #(
            .HAS_PIN  (g < NUM_UNITS - 1),
            .PIN_FALL (IS_U0),
            .PIN_DLY  (IS_U0 ? `TCC_FALL_CAP_DLY : `TCC_RISE_CAP_DLY)
         ) u_unit (
            .sys_clk_i  (sys_clk_i),
            .srst_i     (srst_i),
            .mode_i     (unit_mode[g]),
            .size8_i    (size8),
            .timer_i    (tmr_reg),
            .pin_sync_i (pin_sync[g]),
            .wr_lo_i    (wr_lo[g]),
            .wr_hi_i    (wr_hi[g]),
            .wdata_i    (sfr_wdata_i),
            .value_o    (unit_value[g]),
            .pulse_o    (pulse_w[g]),
            .cap_o      (cap_fire[g])
         );
      end
   endgenerate

   // pulse outputs come straight from the flops inside each unit
   assign unit_pulse_o = pulse_w;

   // read mux; unmapped addresses read as zero
   assign rdata_next =
      (sfr_addr_i == `TCC_ADDR_U0_LO)  ? unit_value[0][7:0]  :
      (sfr_addr_i == `TCC_ADDR_U0_HI)  ? unit_value[0][15:8] :
      (sfr_addr_i == `TCC_ADDR_U1_LO)  ? unit_value[1][7:0]  :
      (sfr_addr_i == `TCC_ADDR_U1_HI)  ? unit_value[1][15:8] :
      (sfr_addr_i == `TCC_ADDR_U2_LO)  ? unit_value[2][7:0]  :
      (sfr_addr_i == `TCC_ADDR_U2_HI)  ? unit_value[2][15:8] :
      (sfr_addr_i == `TCC_ADDR_U3_LO)  ? unit_value[3][7:0]  :
      (sfr_addr_i == `TCC_ADDR_U3_HI)  ? unit_value[3][15:8] :
      (sfr_addr_i == `TCC_ADDR_MODE)   ? unit_mode_enable_reg :
      (sfr_addr_i == `TCC_ADDR_CTRL)   ? timer_control_reg   :
      (sfr_addr_i == `TCC_ADDR_TMR_LO) ? tmr_reg[7:0]        :
      (sfr_addr_i == `TCC_ADDR_TMR_HI) ? tmr_reg[15:8]       : `TCC_BYTE_RESET;

   // control registers and the timer itself
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         timer_control_reg    <= `TCC_BYTE_RESET;
         unit_mode_enable_reg <= `TCC_BYTE_RESET;
         tmr_reg              <= `TCC_WORD_RESET;
         timer_overflow_o     <= 1'b0;
      end else begin
         if (ctrl_wr) begin
            timer_control_reg <= sfr_wdata_i;
         end
         if (mode_wr) begin
            unit_mode_enable_reg <= sfr_wdata_i;
         end
         tmr_reg          <= tmr_next;
         timer_overflow_o <= ovf;
      end
   end

   // read data is held until the next read strobe
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         sfr_rdata_o <= `TCC_BYTE_RESET;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= rdata_next;
      end
   end

   // checks on the logic above

   a_mode_off_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (unit_mode[2] == tcc_pkg::TCC_MODE_OFF) && !wr_lo[2] && !wr_hi[2]
      |=> $stable(unit_value[2]) && !unit_pulse_o[2])
      else $error("disabled unit changed its value or pulsed");

   a_pwm_compare_wide: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (unit_mode[1] == tcc_pkg::TCC_MODE_CMP) && !size8
      |=> unit_pulse_o[1] == ($past(tmr_reg) >= $past(unit_value[1])))
      else $error("unit 1 pulse does not follow the sixteen-bit compare");

   a_soft_capture_wide: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_lo[1] && (unit_mode[1] == tcc_pkg::TCC_MODE_SOFT) && !size8
      |=> unit_value[1] == $past(tmr_reg))
      else $error("low-byte write did not capture the timer");

   a_pin0_fall_capture: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $fell(pin_sync[0]) && (unit_mode[0] == tcc_pkg::TCC_MODE_PIN) && !size8
      |=> unit_value[0] == $past(tmr_reg))
      else $error("unit 0 missed its falling-edge capture");

   a_pin1_rise_capture: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(pin_sync[1]) && (unit_mode[1] == tcc_pkg::TCC_MODE_PIN) && !size8
      ##1 (unit_mode[1] == tcc_pkg::TCC_MODE_PIN)
      |=> unit_value[1] == $past(tmr_reg) && $past(cap_fire[1]))
      else $error("unit 1 rising-edge capture not two cycles later");

   a_pin2_no_early: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(pin_sync[2]) && (unit_mode[2] == tcc_pkg::TCC_MODE_PIN) && !wr_lo[2]
      |-> !cap_fire[2] ##1 cap_fire[2] || (unit_mode[2] != tcc_pkg::TCC_MODE_PIN))
      else $error("unit 2 capture not one cycle after the detected edge");

   a_capture_narrow: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      wr_lo[3] && !wr_hi[3] && (unit_mode[3] == tcc_pkg::TCC_MODE_SOFT) && size8
      |=> unit_value[3] == {$past(unit_value[3][15:8]), $past(tmr_reg[7:0])})
      else $error("eight-bit capture touched the high byte");

   a_timer_narrow: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      size8 && !tmr_hi_wr |=> $stable(tmr_reg[15:8]))
      else $error("eight-bit timer carried into the high byte");

   a_reload_source: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      reload_evt |=> tmr_reg == $past(unit_value[0]))
      else $error("timer reload did not take unit 0 value");

   a_capture_no_disturb: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      (|cap_fire) && run && !size8 && !ovf && !tmr_lo_wr && !tmr_hi_wr
      |=> tmr_reg == ($past(tmr_reg) + `TCC_WORD_ONE))
      else $error("capture disturbed the timer count");

endmodule : tcc_top

`default_nettype wire

// ---- verification/tcc_pin_model.sv ----
// capture pin driver standing in for the outside world
`timescale 1ns/1ps
`default_nettype none

module tcc_pin_model (
   output var logic [2:0] pins_o
);
   // idle levels: unit 0 rests high for its falling edge, units 1 and 2 rest low
   initial pins_o = 3'b001;

   // caller changes levels off the rising edge and holds them several cycles, so the
   // synchroniser always sees each level for at least one full cycle
   // unit 3 has no pin at all, so pin capture is never offered to it
   task automatic drive(input logic [2:0] lvl);
      pins_o = lvl;
   endtask : drive
endmodule : tcc_pin_model
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the timer compare and capture units
`timescale 1ns/1ps
`default_nettype none
`include "tcc_cfg.svh"

module tb;
   logic        sys_clk_i   = 1'b0;
   logic        srst_i      = 1'b1;
   logic [7:0]  sfr_addr_i  = 8'h00;
   logic        sfr_wr_i    = 1'b0;
   logic        sfr_rd_i    = 1'b0;
   logic [7:0]  sfr_wdata_i = 8'h00;
   logic [7:0]  sfr_rdata_o;
   logic [2:0]  pins;
   logic [3:0]  unit_pulse_o;
   logic        timer_overflow_o;
   logic [31:0] seed        = 32'h0000_1D46;
   logic [15:0] tv;
   logic [15:0] val [4];
   logic [3:0]  pexp;
   int          n_mismatch  = 0;
   int          checks_done = 0;
   int          cycles      = 0;

   always #50 sys_clk_i = ~sys_clk_i;

   tcc_top i_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
      .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
      .unit0_capture_pin_i(pins[0]), .unit1_capture_pin_i(pins[1]), .unit2_capture_pin_i(pins[2]),
      .unit_pulse_o(unit_pulse_o), .timer_overflow_o(timer_overflow_o));
   tcc_pin_model i_pins (.pins_o(pins));

   // xorshift source with a fixed start so every run repeats
   function automatic logic [15:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction : rnd

   function automatic logic [7:0] lo_addr(input int g);
      return (g == 0) ? `TCC_ADDR_U0_LO : 8'(8'hC0 + 2 * g);
   endfunction : lo_addr

   // compare output expected one cycle after timer and value settle
   function automatic logic cmp_exp(input logic s8, input logic [15:0] t, input logic [15:0] v);
      return s8 ? (t[7:0] >= v[7:0]) : (t >= v);
   endfunction : cmp_exp

   task automatic summarize();
      if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // bus tasks start at a falling edge and leave the strobe up, so back-to-back access stays legal
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_rd_i = 1'b0;
      sfr_wr_i = 1'b1;
      @(negedge sys_clk_i);
   endtask : wr

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(8'(a + 1), d[15:8]);
   endtask : wr16

   task automatic idle(input int n);
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b0;
      repeat (n) @(negedge sys_clk_i);
   endtask : idle

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr_i = a;
      sfr_wr_i = 1'b0;
      sfr_rd_i = 1'b1;
      @(negedge sys_clk_i);
      check($sformatf("sfr %h", a), {8'h00, sfr_rdata_o}, {8'h00, exp});
   endtask : rdchk

   // pin captures: unit 0 holds timer plus two, units 1 and 2 timer plus three
   task automatic capchk(input logic [15:0] t);
      logic [15:0] e;
      for (int g = 0; g < 3; g++) begin
         e = t + ((g == 0) ? 16'h0002 : 16'h0003);
         rdchk(lo_addr(g), e[7:0]);
         rdchk(8'(lo_addr(g) + 1), e[15:8]);
      end
   endtask : capchk

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (6) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      srst_i = 1'b0;
      // everything reads zero after reset, unmapped slots included
      for (int a = 'hC1; a <= 'hCE; a++) rdchk(8'(a), 8'h00);
      wr(8'hC1, 8'h5A);
      for (int g = 0; g < 4; g++) begin
         val[g] = rnd();
         wr16(lo_addr(g), val[g]);
      end
      rdchk(8'hC1, 8'h00);
      for (int g = 0; g < 4; g++) begin
         rdchk(lo_addr(g), val[g][7:0]);
         rdchk(8'(lo_addr(g) + 1), val[g][15:8]);
      end
      // unit 3 field kept away from pin capture
      pexp = 4'h0;
      tv = rnd() & 16'h00BF;
      wr(`TCC_ADDR_MODE, tv[7:0]);
      rdchk(`TCC_ADDR_MODE, tv[7:0]);
      // clear the modes so a stray 11 field cannot turn the value writes below into captures
      wr(`TCC_ADDR_MODE, 8'h00);
      // compare against a stopped timer, sizes alternating, equality hit on purpose
      for (int r = 0; r < 8; r++) begin
         tv = rnd();
         wr(`TCC_ADDR_CTRL, {2'b00, r[0], 5'b00000});
         wr16(`TCC_ADDR_TMR_LO, tv);
         for (int g = 0; g < 4; g++) begin
            val[g] = (r < 2 && g == r) ? tv : rnd();
            wr16(lo_addr(g), val[g]);
            pexp[g] = cmp_exp(r[0], tv, val[g]);
         end
         wr(`TCC_ADDR_MODE, 8'hAA);
         idle(2);
         check("pulse", {12'h000, unit_pulse_o}, {12'h000, pexp});
      end
      wr(`TCC_ADDR_MODE, 8'h00);
      idle(2);
      check("pulse off", {12'h000, unit_pulse_o}, 16'h0000);
      // capture on low-byte write, sixteen bits then eight
      wr(`TCC_ADDR_CTRL, 8'h00);
      tv = rnd();
      wr16(`TCC_ADDR_TMR_LO, tv);
      wr(`TCC_ADDR_MODE, 8'hFF);
      for (int g = 0; g < 4; g++) begin
         wr(lo_addr(g), 8'hA5);
         rdchk(lo_addr(g), tv[7:0]);
         rdchk(8'(lo_addr(g) + 1), tv[15:8]);
      end
      rdchk(`TCC_ADDR_TMR_LO, tv[7:0]);
      wr(`TCC_ADDR_CTRL, 8'h20);
      for (int g = 0; g < 4; g++) begin
         val[g] = rnd();
         wr(8'(lo_addr(g) + 1), val[g][15:8]);
         wr(lo_addr(g), val[g][7:0]);
         rdchk(lo_addr(g), tv[7:0]);
         rdchk(8'(lo_addr(g) + 1), val[g][15:8]);
      end
      // pin capture on a running timer, unit 3 comparing beside it
      tv = rnd() & 16'h7FFF;
      wr(`TCC_ADDR_CTRL, 8'h00);
      wr16(`TCC_ADDR_TMR_LO, tv);
      wr16(lo_addr(3), 16'h0000);
      wr(`TCC_ADDR_MODE, 8'h95);
      wr(`TCC_ADDR_CTRL, 8'h01);
      i_pins.drive(3'b110);
      idle(6);
      check("pulse mix", {12'h000, unit_pulse_o}, 16'h0008);
      capchk(tv);
      // opposite edges must not capture while the timer keeps moving
      i_pins.drive(3'b001);
      idle(6);
      capchk(tv);
      // disabled units ignore their pins
      wr(`TCC_ADDR_MODE, 8'h00);
      i_pins.drive(3'b110);
      idle(6);
      capchk(tv);
      i_pins.drive(3'b001);
      // reload takes unit 0 only, the others hold different values
      wr(`TCC_ADDR_CTRL, 8'h00);
      val[0] = {rnd() & 16'h7F7F};
      wr16(lo_addr(0), val[0]);
      for (int g = 1; g < 4; g++) wr16(lo_addr(g), val[0] ^ 16'h5A00);
      wr16(`TCC_ADDR_TMR_LO, 16'hFFFD);
      wr(`TCC_ADDR_CTRL, 8'h11);
      idle(2);
      check("overflow early", {15'h0000, timer_overflow_o}, 16'h0000);
      idle(1);
      check("overflow", {15'h0000, timer_overflow_o}, 16'h0001);
      rdchk(`TCC_ADDR_TMR_LO, val[0][7:0]);
      rdchk(`TCC_ADDR_TMR_HI, val[0][15:8]);
      // eight-bit counting wraps the low byte and freezes the high one
      wr(`TCC_ADDR_CTRL, 8'h00);
      wr16(`TCC_ADDR_TMR_LO, 16'h12FE);
      wr(`TCC_ADDR_CTRL, 8'h21);
      idle(2);
      rdchk(`TCC_ADDR_TMR_LO, 8'h00);
      rdchk(`TCC_ADDR_TMR_HI, 8'h12);
      summarize();
   end
endmodule : tb
`default_nettype wire
